// ===== seq_pkg.sv
// Shared constants, types and configuration layout of the rail strobe sequencer
package seq_pkg;

  // Clock and time base
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned MS_PER_S = 1000;
  localparam int unsigned GAP_MIN_MS = 2;
  localparam int unsigned GAP_MAX_MS = 5;
  localparam int unsigned PD_FACTOR = 10;
  localparam int unsigned WAIT_TIMEOUT_S = 20;
  localparam int unsigned PRESS_DEFAULT_S = 8;
  localparam int unsigned PRESS_LONG_S = 15;
  localparam int unsigned PD_TOTAL_MS = 500;

  // Structure
  localparam int N_RAILS = 10;
  localparam int N_SEQ_RAILS = 8;
  localparam int N_GAPS = 9;
  localparam int STROBE_W = 4;
  localparam int GAP_CODE_W = 2;
  localparam int TIMER_W = 32;

  // Rail positions in the enable and discharge vectors
  localparam int RAIL_DCDC1 = 0;
  localparam int RAIL_DCDC4 = 3;
  localparam int RAIL_GENERAL_LINEAR_REG = 4;
  localparam int RAIL_LOAD_SWITCH_ONE = 5;
  localparam int RAIL_BACKUP_RAIL_A = 6;
  localparam int RAIL_BACKUP_RAIL_B = 7;
  localparam int RAIL_LOAD_SWITCH_TWO = 8;
  localparam int RAIL_LOAD_SWITCH_THREE = 9;

  // Strobe numbers
  localparam logic [STROBE_W-1:0] STROBE_NONE = 4'h0;
  localparam logic [STROBE_W-1:0] FIRST_STROBE = 4'h1;
  localparam logic [STROBE_W-1:0] BACKUP_LAST_STROBE = 4'h2;
  localparam logic [STROBE_W-1:0] MAIN_FIRST_STROBE = 4'h3;
  localparam logic [STROBE_W-1:0] TENTH_STROBE = 4'ha;
  localparam logic [STROBE_W-1:0] STROBE_STEP = 4'h1;

  // Reset values
  localparam logic [N_RAILS-1:0] RAIL_EN_RST = 10'h000;
  localparam logic [N_RAILS-1:0] RAIL_DIS_RST = 10'h3ff;
  localparam logic [TIMER_W-1:0] TIMER_ZERO = 32'h0000_0000;
  localparam logic [TIMER_W-1:0] TIMER_ONE = 32'h0000_0001;

  typedef enum logic [2:0] {
    ST_OFF = 3'b000,
    ST_PRE_OFF = 3'b001,
    ST_AWAIT_HOST = 3'b010,
    ST_ACTIVE = 3'b011,
    ST_SUSPEND = 3'b100,
    ST_RECOVERY = 3'b101,
    ST_PWR_DOWN = 3'b110
  } pwr_state_t;

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_UP = 2'b01,
    SEQ_DOWN = 2'b10
  } seq_mode_t;

  typedef struct packed {
    logic [N_SEQ_RAILS-1:0][STROBE_W-1:0] strobe_assignment;
    logic [N_GAPS-1:0][GAP_CODE_W-1:0] strobe_gap_delay;
    logic powerdown_delay_factor;
    logic backup_seal_bit;
    logic long_reset_opt;
  } seq_cfg_t;

  typedef struct packed {
    logic push_button_in;
    logic adapter_detect_in;
    logic host_power_enable;
  } wake_pins_t;

  typedef struct packed {
    logic undervoltage_lockout;
    logic overheat_shutdown;
    logic rails_good_flag;
  } fault_in_t;

endpackage

// ===== hold_timer.sv
// Saturating cycle counter that flags when a programmed limit is reached
`timescale 1ns/1ns
module hold_timer
  import seq_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic run,
  input wire logic restart,
  input wire logic [TIMER_W-1:0] limit,
  output logic done
);

  logic [TIMER_W-1:0] count_reg;
  logic [TIMER_W-1:0] count_next;

  assign done = (count_reg >= limit);

  always_comb begin
    count_next = count_reg;
    if (restart) begin
      count_next = TIMER_ZERO;
    end else if (run && !done) begin
      count_next = count_reg + TIMER_ONE;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      count_reg <= TIMER_ZERO;
    end else begin
      count_reg <= count_next;
    end
  end

endmodule

// ===== rail_strobe_sequencer.sv
// Power state machine and ten-strobe rail sequencer of the power manager
`timescale 1ns/1ns
module rail_strobe_sequencer
  import seq_pkg::*;
#(
  parameter int unsigned MS_CYCLES = CLK_HZ / MS_PER_S,
  parameter int unsigned WAIT_TIMEOUT_CYCLES = WAIT_TIMEOUT_S * CLK_HZ,
  parameter int unsigned PRESS_DEFAULT_CYCLES = PRESS_DEFAULT_S * CLK_HZ,
  parameter int unsigned PRESS_LONG_CYCLES = PRESS_LONG_S * CLK_HZ,
  parameter int unsigned PD_TOTAL_CYCLES = PD_TOTAL_MS * (CLK_HZ / MS_PER_S)
)
(
  input wire logic clk,
  input wire logic arst_n,
  input wire wake_pins_t pins,
  input wire fault_in_t faults,
  input wire seq_cfg_t cfg,
  input wire logic enable_write,
  input wire logic [N_RAILS-1:0] enable_write_data,
  output logic [N_RAILS-1:0] rail_enable,
  output logic [N_RAILS-1:0] rail_discharge,
  output pwr_state_t power_state,
  output logic sequencer_busy
);

  // Gap length in cycles for a gap code, stretched on power-down when asked
  function automatic logic [TIMER_W-1:0] gap_cycles(input logic [GAP_CODE_W-1:0] code,
                                                    input logic stretch);
    logic [TIMER_W-1:0] ms;
    ms = TIMER_W'(GAP_MIN_MS) + TIMER_W'(code);
    if (ms > TIMER_W'(GAP_MAX_MS)) begin
      ms = TIMER_W'(GAP_MAX_MS);
    end
    ms = ms * TIMER_W'(MS_CYCLES);
    if (stretch) begin
      ms = ms * TIMER_W'(PD_FACTOR);
    end
    return ms;
  endfunction

  // True when rail idx belongs to strobe s; backup rails only on strobes one and two, other rails only on strobe three and later
  function automatic logic strobe_hits(input int idx, input logic [STROBE_W-1:0] code,
                                       input logic [STROBE_W-1:0] s);
    logic backup;
    backup = (idx == RAIL_BACKUP_RAIL_A) || (idx == RAIL_BACKUP_RAIL_B);
    if (code == STROBE_NONE || code != s) begin
      return 1'b0;
    end
    if (backup) begin
      return (s <= BACKUP_LAST_STROBE);
    end
    return (s >= MAIN_FIRST_STROBE);
  endfunction

  // Main state
  pwr_state_t state_reg;
  pwr_state_t state_next;
  pwr_state_t target_reg;
  pwr_state_t target_next;
  logic pb_prev_reg;
  logic ac_prev_reg;
  logic host_prev_reg;

  // Sequencer state
  seq_mode_t mode_reg;
  seq_mode_t mode_next;
  logic [STROBE_W-1:0] strobe_reg;
  logic [STROBE_W-1:0] strobe_next;
  logic first_reg;
  logic first_next;
  logic [STROBE_W-1:0] gap_sel_reg;
  logic [STROBE_W-1:0] gap_sel_next;

  // Rails
  logic [N_RAILS-1:0] rail_en_reg;
  logic [N_RAILS-1:0] rail_en_next;
  logic [N_RAILS-1:0] discharge_reg;
  logic [N_RAILS-1:0] discharge_next;

  // Events and timers
  logic pb_fall;
  logic ac_fall;
  logic host_rise;
  logic fault_trip;
  logic good_fail;
  logic wake_ok;
  logic start_up;
  logic start_down;
  logic fire;
  logic gap_done;
  logic state_done;
  logic press_done;
  logic press_run;
  logic idle_hold;
  logic [TIMER_W-1:0] gap_limit;
  logic [TIMER_W-1:0] state_limit;
  logic [TIMER_W-1:0] press_limit;

  assign pb_fall = pb_prev_reg && !pins.push_button_in;
  assign ac_fall = ac_prev_reg && !pins.adapter_detect_in;
  assign host_rise = !host_prev_reg && pins.host_power_enable;
  assign wake_ok = !faults.undervoltage_lockout && !faults.overheat_shutdown;
  assign fault_trip = !wake_ok;
  // Supervisor loss only counts once the rails have been fully brought up
  assign good_fail = (state_reg == ST_ACTIVE) && (mode_reg == SEQ_IDLE) &&
                     !faults.rails_good_flag;
  assign sequencer_busy = (mode_reg != SEQ_IDLE) || (state_reg == ST_PWR_DOWN);
  assign fire = (mode_reg != SEQ_IDLE) && (first_reg || gap_done);
  assign idle_hold = !pins.push_button_in || !pins.adapter_detect_in ||
                     pins.host_power_enable;
  assign press_run = !pins.push_button_in &&
                     ((state_reg == ST_AWAIT_HOST) || (state_reg == ST_ACTIVE) ||
                      (state_reg == ST_SUSPEND));
  assign gap_limit = gap_cycles(cfg.strobe_gap_delay[gap_sel_reg],
                                (mode_reg == SEQ_DOWN) && cfg.powerdown_delay_factor);
  assign state_limit = (state_reg == ST_PWR_DOWN) ? TIMER_W'(PD_TOTAL_CYCLES) :
                       TIMER_W'(WAIT_TIMEOUT_CYCLES);
  assign press_limit = cfg.long_reset_opt ? TIMER_W'(PRESS_LONG_CYCLES) :
                       TIMER_W'(PRESS_DEFAULT_CYCLES);

  hold_timer u_gap_timer (
    .clk(clk),
    .arst_n(arst_n),
    .run(mode_reg != SEQ_IDLE),
    .restart(fire || start_up || start_down),
    .limit(gap_limit),
    .done(gap_done)
  );

  hold_timer u_state_timer (
    .clk(clk),
    .arst_n(arst_n),
    .run(1'b1),
    .restart((state_next != state_reg) ||
             ((state_reg == ST_AWAIT_HOST) && idle_hold)),
    .limit(state_limit),
    .done(state_done)
  );

  hold_timer u_press_timer (
    .clk(clk),
    .arst_n(arst_n),
    .run(press_run),
    .restart(!press_run || (state_next != state_reg)),
    .limit(press_limit),
    .done(press_done)
  );

  // Power state transitions
  always_comb begin
    state_next = state_reg;
    target_next = target_reg;
    start_up = 1'b0;
    start_down = 1'b0;
    case (state_reg)
      ST_OFF: begin
        if (wake_ok && (pb_fall || ac_fall || host_rise || !pins.adapter_detect_in)) begin
          start_up = 1'b1;
        end
      end
      ST_PRE_OFF: begin
        if (wake_ok && (pb_fall || ac_fall || host_rise)) begin
          start_up = 1'b1;
        end
      end
      ST_SUSPEND: begin
        if (fault_trip) begin
          start_down = 1'b1;
          target_next = ST_RECOVERY;
        end else if (press_done) begin
          start_down = 1'b1;
          target_next = ST_PRE_OFF;
        end else if (pb_fall || ac_fall || pins.host_power_enable) begin
          start_up = 1'b1;
        end
      end
      ST_AWAIT_HOST: begin
        if (fault_trip) begin
          start_down = 1'b1;
          target_next = ST_RECOVERY;
        end else if (press_done || state_done) begin
          start_down = 1'b1;
          target_next = ST_PRE_OFF;
        end else if (pins.host_power_enable) begin
          state_next = ST_ACTIVE;
        end
      end
      ST_ACTIVE: begin
        if (fault_trip || good_fail) begin
          start_down = 1'b1;
          target_next = ST_RECOVERY;
        end else if (press_done) begin
          start_down = 1'b1;
          target_next = ST_PRE_OFF;
        end else if (!pins.host_power_enable) begin
          start_down = 1'b1;
          target_next = ST_SUSPEND;
        end
      end
      ST_RECOVERY: begin
        if (wake_ok) begin
          start_up = 1'b1;
        end
      end
      ST_PWR_DOWN: begin
        if (state_done) begin
          state_next = target_reg;
        end
      end
      default: begin
        state_next = ST_OFF;
      end
    endcase
    if (start_up) begin
      state_next = ST_AWAIT_HOST;
    end
    if (start_down) begin
      state_next = ST_PWR_DOWN;
    end
  end

  // Strobe stepping
  always_comb begin
    mode_next = mode_reg;
    strobe_next = strobe_reg;
    first_next = 1'b0;
    gap_sel_next = gap_sel_reg;
    if (start_down) begin
      mode_next = SEQ_DOWN;
      strobe_next = TENTH_STROBE;
      first_next = 1'b1;
    end else if (start_up) begin
      mode_next = SEQ_UP;
      strobe_next = FIRST_STROBE;
      first_next = 1'b1;
    end else if (state_reg == ST_PWR_DOWN && state_done) begin
      mode_next = SEQ_IDLE;
    end else if (fire) begin
      case (mode_reg)
        SEQ_UP: begin
          if (strobe_reg == TENTH_STROBE) begin
            mode_next = SEQ_IDLE;
          end else begin
            gap_sel_next = strobe_reg - FIRST_STROBE;
            strobe_next = strobe_reg + STROBE_STEP;
          end
        end
        SEQ_DOWN: begin
          if (strobe_reg == FIRST_STROBE ||
              (strobe_reg == MAIN_FIRST_STROBE && cfg.backup_seal_bit)) begin
            mode_next = SEQ_IDLE;
          end else begin
            gap_sel_next = strobe_reg - BACKUP_LAST_STROBE;
            strobe_next = strobe_reg - STROBE_STEP;
          end
        end
        default: begin
          mode_next = SEQ_IDLE;
        end
      endcase
    end
  end

  // Rail enables and discharge paths
  always_comb begin
    rail_en_next = rail_en_reg;
    if (enable_write && !sequencer_busy) begin
      rail_en_next = enable_write_data;
    end
    if (fire) begin
      for (int i = 0; i < N_SEQ_RAILS; i++) begin
        if (strobe_hits(i, cfg.strobe_assignment[i], strobe_reg)) begin
          rail_en_next[i] = (mode_reg == SEQ_UP);
        end
      end
    end
    if (start_down && target_next != ST_SUSPEND) begin
      for (int i = RAIL_DCDC1; i <= RAIL_LOAD_SWITCH_ONE; i++) begin
        if (cfg.strobe_assignment[i] == STROBE_NONE) begin
          rail_en_next[i] = 1'b0;
        end
      end
    end
    if (state_reg == ST_PWR_DOWN && state_done && target_reg != ST_SUSPEND) begin
      rail_en_next[RAIL_LOAD_SWITCH_TWO] = 1'b0;
      rail_en_next[RAIL_LOAD_SWITCH_THREE] = 1'b0;
    end
    discharge_next = ~rail_en_next;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= ST_OFF;
      target_reg <= ST_PRE_OFF;
      pb_prev_reg <= 1'b1;
      ac_prev_reg <= 1'b1;
      host_prev_reg <= 1'b0;
      mode_reg <= SEQ_IDLE;
      strobe_reg <= STROBE_NONE;
      first_reg <= 1'b0;
      gap_sel_reg <= STROBE_NONE;
      rail_en_reg <= RAIL_EN_RST;
      discharge_reg <= RAIL_DIS_RST;
    end else begin
      state_reg <= state_next;
      target_reg <= target_next;
      pb_prev_reg <= pins.push_button_in;
      ac_prev_reg <= pins.adapter_detect_in;
      host_prev_reg <= pins.host_power_enable;
      mode_reg <= mode_next;
      strobe_reg <= strobe_next;
      first_reg <= first_next;
      gap_sel_reg <= gap_sel_next;
      rail_en_reg <= rail_en_next;
      discharge_reg <= discharge_next;
    end
  end

  assign rail_enable = rail_en_reg;
  assign rail_discharge = discharge_reg;
  assign power_state = state_reg;

endmodule

// ===== rail_strobe_sequencer_properties.sv
// Checker of the rail strobe sequencer port behaviour
`timescale 1ns/1ns
module rail_strobe_sequencer_properties
  import seq_pkg::*;
#(
  parameter int unsigned PD_TOTAL_CYCLES = 500
)
(
  input wire logic clk,
  input wire logic arst_n,
  input wire wake_pins_t pins,
  input wire fault_in_t faults,
  input wire logic enable_write,
  input wire logic [N_RAILS-1:0] enable_write_data,
  input wire logic [N_RAILS-1:0] rail_enable,
  input wire logic [N_RAILS-1:0] rail_discharge,
  input wire pwr_state_t power_state,
  input wire logic sequencer_busy
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  logic [TIMER_W-1:0] pd_cnt_reg;
  logic [TIMER_W-1:0] pd_cnt_next;
  logic in_pd;
  logic no_block;
  assign in_pd = power_state == ST_PWR_DOWN;
  assign no_block = !faults.undervoltage_lockout && !faults.overheat_shutdown;
  always_comb begin
    pd_cnt_next = in_pd ? pd_cnt_reg + TIMER_ONE : TIMER_ZERO;
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pd_cnt_reg <= TIMER_ZERO;
    end else begin
      pd_cnt_reg <= pd_cnt_next;
    end
  end
  sequence s_woken;
    ##1 power_state == ST_AWAIT_HOST && sequencer_busy;
  endsequence
  sequence s_pd_last;
    in_pd && pd_cnt_reg == PD_TOTAL_CYCLES;
  endsequence
  property p_wake_off;
    power_state == ST_OFF && $fell(pins.push_button_in) && no_block |-> s_woken;
  endproperty
  a_wake_off: assert property (p_wake_off) else $error("no wake from off");
  property p_active;
    power_state == ST_AWAIT_HOST && pins.host_power_enable && no_block
      |=> power_state == ST_ACTIVE;
  endproperty
  a_active: assert property (p_active) else $error("host enable ignored");
  property p_host_drop;
    power_state == ST_ACTIVE && !pins.host_power_enable |=> in_pd;
  endproperty
  a_host_drop: assert property (p_host_drop) else $error("host low kept active");
  property p_pd_exit;
    s_pd_last |=> !in_pd;
  endproperty
  a_pd_exit: assert property (p_pd_exit) else $error("power-down too long");
  property p_pd_no_early;
    $fell(in_pd) |-> $past(pd_cnt_reg) == PD_TOTAL_CYCLES;
  endproperty
  a_pd_no_early: assert property (p_pd_no_early) else $error("power-down too short");
  property p_ls_drop;
    s_pd_last ##1 power_state != ST_SUSPEND
      |-> rail_enable[RAIL_LOAD_SWITCH_THREE:RAIL_LOAD_SWITCH_TWO] == 2'b00;
  endproperty
  a_ls_drop: assert property (p_ls_drop) else $error("load switches left on");
  property p_ls_hold;
    in_pd ##1 in_pd |-> $stable(rail_enable[RAIL_LOAD_SWITCH_THREE:RAIL_LOAD_SWITCH_TWO]);
  endproperty
  a_ls_hold: assert property (p_ls_hold) else $error("load switch moved early");
  property p_discharge;
    rail_discharge == ~rail_enable;
  endproperty
  a_discharge: assert property (p_discharge) else $error("discharge mismatch");
  property p_write;
    enable_write && !sequencer_busy ##1 power_state == $past(power_state)
      |-> rail_enable == $past(enable_write_data);
  endproperty
  a_write: assert property (p_write) else $error("write not taken");
  property p_up_keep;
    sequencer_busy && power_state inside {ST_AWAIT_HOST, ST_ACTIVE}
      ##1 power_state inside {ST_AWAIT_HOST, ST_ACTIVE}
      |-> ($past(rail_enable) & ~rail_enable) == '0;
  endproperty
  a_up_keep: assert property (p_up_keep) else $error("rail dropped in power-up");
endmodule

bind rail_strobe_sequencer rail_strobe_sequencer_properties #(
  .PD_TOTAL_CYCLES(PD_TOTAL_CYCLES)
) u_rail_strobe_sequencer_properties (
  .clk, .arst_n, .pins, .faults, .enable_write, .enable_write_data,
  .rail_enable, .rail_discharge, .power_state, .sequencer_busy
);

// ===== host_model.sv
// Host processor, push-button and adapter as seen at the wake pins
`timescale 1ns/1ns
module host_model
  import seq_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic host_on,
  input wire logic press,
  input wire logic adapter_low,
  output wake_pins_t pins
);
  wake_pins_t pins_reg;
  wake_pins_t pins_next;
  always_comb begin
    pins_next.push_button_in = !press;
    pins_next.adapter_detect_in = !adapter_low;
    pins_next.host_power_enable = host_on;
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pins_reg <= 3'b110;
    end else begin
      pins_reg <= pins_next;
    end
  end
  assign pins = pins_reg;
endmodule

// ===== tb.sv
// Self-checking bench of the rail strobe sequencer
`timescale 1ns/1ns
module tb;
  import seq_pkg::*;
  localparam int unsigned MS = 4;
  localparam int unsigned PDT = 1000;
  localparam int PRESS = 80;
  localparam int WAIT = 200;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic host_on = 1'b0;
  logic press = 1'b0;
  logic adapter_low = 1'b0;
  wake_pins_t pins;
  fault_in_t faults = 3'b001;
  seq_cfg_t cfg = '0;
  logic enable_write = 1'b0;
  logic [N_RAILS-1:0] enable_write_data = '0;
  logic [N_RAILS-1:0] rail_enable;
  logic [N_RAILS-1:0] rail_discharge;
  pwr_state_t power_state;
  logic sequencer_busy;
  int errors = 0;
  int tests_run = 0;
  int n;
  always #20 clk = ~clk;
  host_model u_host_model (
    .clk, .arst_n, .host_on, .press, .adapter_low, .pins
  );
  rail_strobe_sequencer #(
    .MS_CYCLES(MS), .WAIT_TIMEOUT_CYCLES(WAIT), .PRESS_DEFAULT_CYCLES(PRESS),
    .PRESS_LONG_CYCLES(150), .PD_TOTAL_CYCLES(PDT)
  ) u_rail_strobe_sequencer (
    .clk, .arst_n, .pins, .faults, .cfg, .enable_write, .enable_write_data,
    .rail_enable, .rail_discharge, .power_state, .sequencer_busy
  );
  task automatic report_and_stop();
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk_vec(input string what, input logic [N_RAILS-1:0] exp,
                         input logic [N_RAILS-1:0] got);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_cnt(input string what, input int exp, input int got);
    tests_run++;
    if (got != exp) begin
      errors++;
      $display("CHECK FAILED %s expected %0d seen %0d", what, exp, got);
    end
  endtask
  task automatic step();
    @(negedge clk);
    n++;
    if (n > 3000) begin
      errors++;
      $display("CHECK FAILED wait expected done seen timeout");
      report_and_stop();
    end
  endtask
  task automatic wait_st(input pwr_state_t s);
    n = 0;
    while (power_state !== s) step();
  endtask
  task automatic wait_bit(input int i, input logic v);
    n = 0;
    while (rail_enable[i] !== v) step();
  endtask
  task automatic wait_idle();
    n = 0;
    while (sequencer_busy !== 1'b0) step();
  endtask
  task automatic drive_write(input logic [N_RAILS-1:0] d);
    @(posedge clk);
    enable_write <= 1'b1;
    enable_write_data <= d;
    @(posedge clk);
    enable_write <= 1'b0;
  endtask
  task automatic t_reset_write();
    @(negedge clk);
    chk_vec("reset enables", RAIL_EN_RST, rail_enable);
    chk_vec("reset discharge", RAIL_DIS_RST, rail_discharge);
    drive_write(10'h312);
    @(negedge clk);
    chk_vec("idle write", 10'h312, rail_enable);
    $display("test reset_write done");
  endtask
  task automatic t_power_up();
    @(posedge clk);
    press <= 1'b1;
    wait_st(ST_AWAIT_HOST);
    @(posedge clk);
    press <= 1'b0;
    wait_bit(RAIL_BACKUP_RAIL_A, 1'b1);
    chk_cnt("first strobe", 1, n);
    wait_bit(RAIL_BACKUP_RAIL_B, 1'b1);
    chk_cnt("first gap", 5 * MS + 1, n);
    drive_write(10'h000);
    wait_idle();
    chk_vec("after power-up", 10'h3df, rail_enable);
    @(posedge clk);
    host_on <= 1'b1;
    wait_st(ST_ACTIVE);
    $display("test power_up done");
  endtask
  task automatic t_power_down();
    @(posedge clk);
    host_on <= 1'b0;
    wait_st(ST_PWR_DOWN);
    chk_vec("down start", 10'h3df, rail_enable);
    wait_bit(RAIL_DCDC4, 1'b0);
    chk_cnt("tenth strobe", 1, n);
    wait_bit(RAIL_DCDC1, 1'b0);
    chk_cnt("down gaps", 7 * (GAP_MIN_MS * MS * PD_FACTOR + 1), n);
    wait_st(ST_SUSPEND);
    chk_vec("after down", 10'h312, rail_enable);
    $display("test power_down done");
  endtask
  task automatic t_seal_fault();
    @(posedge clk);
    cfg.backup_seal_bit <= 1'b1;
    host_on <= 1'b1;
    wait_st(ST_ACTIVE);
    wait_idle();
    chk_vec("second power-up", 10'h3df, rail_enable);
    @(posedge clk);
    faults <= 3'b101;
    host_on <= 1'b0;
    wait_st(ST_PWR_DOWN);
    chk_vec("fault down start", 10'h3cd, rail_enable);
    wait_st(ST_RECOVERY);
    chk_vec("sealed backup", 10'h0c0, rail_enable);
    @(posedge clk);
    faults <= 3'b001;
    wait_st(ST_AWAIT_HOST);
    $display("test seal_fault done");
  endtask
  task automatic t_long_press();
    @(posedge clk);
    press <= 1'b1;
    wait_st(ST_PWR_DOWN);
    chk_cnt("long press", 1, int'(n >= PRESS - 1 && n <= PRESS + 3));
    @(posedge clk);
    press <= 1'b0;
    $display("test long_press done");
  endtask
  task automatic t_idle_timeout();
    wait_st(ST_PRE_OFF);
    @(posedge clk);
    adapter_low <= 1'b1;
    wait_st(ST_AWAIT_HOST);
    @(posedge clk);
    adapter_low <= 1'b0;
    wait_st(ST_PWR_DOWN);
    // One cycle of pin latency, the restart cycle before counting, and one cycle to register the state
    chk_cnt("idle timeout", WAIT + 3, n);
    wait_st(ST_PRE_OFF);
    $display("test idle_timeout done");
  endtask
  initial begin
    cfg.strobe_assignment = 32'h2100_a503;
    cfg.strobe_gap_delay = 18'h00003;
    cfg.powerdown_delay_factor = 1'b1;
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    t_reset_write();
    t_power_up();
    t_power_down();
    t_seal_fault();
    t_long_press();
    t_idle_timeout();
    report_and_stop();
  end
endmodule
